// ### mscr_regs.sv
// register bank for the message interrupt and subsystem capabilities
// What this block does; RQ9 is left to software
// RQ1: the message capability header reads 0x5 in its low byte.
// RQ2: the next link in header bits 15:8 resets to 0 and is lock-writable.
// RQ3: header bit 16 is a writable enable, reset 0, gating message sends.
// RQ4: the requested count in bits 19:17 is read-only zero.
// RQ5: granted count in bits 22:20 resets 0; one message always used.
// RQ6: header bit 23 reads 1, advertising wide address support.
// RQ7: low address bits 31:2 are writable, bits 1:0 read zero.
// RQ8: a nonzero upper address selects a wide write, zero a narrow one.
// RQ9: software must aim all target addresses at the root port.
// RQ10: payload bits 15:0 writable, reset 0, bits 31:16 read zero.
// RQ11: the subsystem capability header reads 0xd in its low byte.
// RQ12: subsystem next link bits 15:8 reset 0, lock-writable; rest zero.
// RQ13: subsystem bits 15:0 hold the lock-writable board maker code.
// RQ14: subsystem bits 31:16 hold the lock-writable board code.
// RQ15: an enabled event emits one posted write of payload to target.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mscr_regs (
    input  wire logic                          ref_clk,
    input  wire logic                          srst,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [11:0]                   paddr,
    input  wire logic [31:0]                   pwdata,
    input  wire logic [3:0]                    pstrb,
    output logic                               pready,
    output logic                               pslverr,
    output logic [31:0]                        prdata,
    input  wire logic                          irq_event,
    input  wire logic                          wr_ready,
    output logic                               wr_valid,
    output logic                               wr_wide,
    output logic [63:0]                        wr_addr,
    output logic [31:0]                        wr_data,
    output logic                               irq
);
    import mscr_pkg::*;

    typedef struct packed {
        logic [7:0]          msg_link;
        logic                msg_enable;
        logic [2:0]          grant_count;
        logic [29:0]         addr_low;
        logic [31:0]         addr_high;
        logic [15:0]         payload;
        logic [7:0]          sub_link;
        logic [15:0]         board_maker_code;
        logic [15:0]         board_code;
        logic                cfg_unlocked;
        logic [IRQ_BITS-1:0] status;
        logic [IRQ_BITS-1:0] irq_enable;
        logic                pready;
        logic                pslverr;
        logic [31:0]         prdata;
        logic                irq;
    } mscr_regs_t;

    mscr_regs_t r;
    mscr_regs_t next_r;

    logic       sent_pulse;
    logic       drop_pulse;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [31:0] ctrl_word(input mscr_regs_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[7:0] = MSG_CAP_ID; // RQ1
        w[LINK_LSB +: 8] = s.msg_link;
        w[ENABLE_BIT] = s.msg_enable;
        w[REQ_COUNT_LSB +: 3] = REQ_COUNT_VALUE; // RQ4
        w[GRANT_COUNT_LSB +: 3] = s.grant_count;
        w[WIDE_BIT] = WIDE_ADDR_VALUE; // RQ6
        return w;
    endfunction

    // register picked by the bus address
    typedef enum logic [3:0] {
        MSCR_SEL_CTRL,
        MSCR_SEL_ADDR_LO,
        MSCR_SEL_ADDR_HI,
        MSCR_SEL_PAYLOAD,
        MSCR_SEL_SUB_HDR,
        MSCR_SEL_SUB_ID,
        MSCR_SEL_STATUS,
        MSCR_SEL_ENABLE,
        MSCR_SEL_CLEAR,
        MSCR_SEL_LOCK,
        MSCR_SEL_NONE
    } mscr_sel_t;

    // one address decode shared by the read and write paths
    function automatic mscr_sel_t reg_select(input logic [11:0] a);
        mscr_sel_t s;
        unique case (a)
            OFF_MSG_CTRL:    s = MSCR_SEL_CTRL;
            OFF_MSG_ADDR_LO: s = MSCR_SEL_ADDR_LO;
            OFF_MSG_ADDR_HI: s = MSCR_SEL_ADDR_HI;
            OFF_MSG_PAYLOAD: s = MSCR_SEL_PAYLOAD;
            OFF_SUB_HDR:     s = MSCR_SEL_SUB_HDR;
            OFF_SUB_ID:      s = MSCR_SEL_SUB_ID;
            OFF_IRQ_STATUS:  s = MSCR_SEL_STATUS;
            OFF_IRQ_ENABLE:  s = MSCR_SEL_ENABLE;
            OFF_IRQ_CLEAR:   s = MSCR_SEL_CLEAR;
            OFF_LOCK:        s = MSCR_SEL_LOCK;
            default:         s = MSCR_SEL_NONE;
        endcase
        return s;
    endfunction

    // word as read; also the old value that a strobed write merges into
    function automatic logic [31:0] reg_word(input mscr_regs_t s,
                                             input mscr_sel_t  sel);
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (sel)
            MSCR_SEL_CTRL:    w = ctrl_word(s);
            MSCR_SEL_ADDR_LO: w = {s.addr_low, 2'b00}; // RQ7
            MSCR_SEL_ADDR_HI: w = s.addr_high;
            MSCR_SEL_PAYLOAD: w = {16'h0000, s.payload}; // RQ10
            MSCR_SEL_SUB_HDR: w = {16'h0000, s.sub_link, SUB_CAP_ID}; // RQ11
            MSCR_SEL_SUB_ID:  w = {s.board_code, s.board_maker_code};
            MSCR_SEL_STATUS:  w = 32'(s.status);
            MSCR_SEL_ENABLE:  w = 32'(s.irq_enable);
            MSCR_SEL_LOCK:    w = 32'(s.cfg_unlocked);
            default:          w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    logic        access;
    logic        wr_acc;
    logic        rd_acc;
    mscr_sel_t   sel;
    logic [31:0] mw;

    always_comb begin
        access = psel && penable && !r.pready;
        wr_acc = access && pwrite;
        rd_acc = access && !pwrite;
        sel    = reg_select(paddr);
        mw     = merge(reg_word(r, sel), pwdata, pstrb);
        next_r = r;
        next_r.pready  = access;
        next_r.pslverr = 1'b0;
        if (rd_acc) begin
            next_r.prdata  = reg_word(r, sel);
            // clear register is write-only
            next_r.pslverr = (sel == MSCR_SEL_NONE) ||
                             (sel == MSCR_SEL_CLEAR);
        end
        if (wr_acc) begin
            unique case (sel)
                MSCR_SEL_CTRL: begin
                    if (r.cfg_unlocked) begin
                        next_r.msg_link = mw[LINK_LSB +: 8]; // RQ2
                    end
                    next_r.msg_enable  = mw[ENABLE_BIT]; // RQ3
                    next_r.grant_count = mw[GRANT_COUNT_LSB +: 3]; // RQ5
                end
                MSCR_SEL_ADDR_LO: begin
                    next_r.addr_low = mw[31:2]; // RQ7
                end
                MSCR_SEL_ADDR_HI: begin
                    next_r.addr_high = mw;
                end
                MSCR_SEL_PAYLOAD: begin
                    next_r.payload = mw[15:0]; // RQ10
                end
                MSCR_SEL_SUB_HDR: begin
                    if (r.cfg_unlocked) begin
                        next_r.sub_link = mw[LINK_LSB +: 8]; // RQ12
                    end
                end
                MSCR_SEL_SUB_ID: begin
                    if (r.cfg_unlocked) begin
                        next_r.board_maker_code = mw[MAKER_LSB +: 16]; // RQ13
                        next_r.board_code = mw[BOARD_LSB +: 16]; // RQ14
                    end
                end
                MSCR_SEL_ENABLE: begin
                    next_r.irq_enable = mw[IRQ_BITS-1:0];
                end
                MSCR_SEL_CLEAR: begin
                    next_r.status = r.status & ~mw[IRQ_BITS-1:0];
                end
                MSCR_SEL_LOCK: begin
                    next_r.cfg_unlocked = mw[0];
                end
                default: begin
                    // status is read-only; unmapped writes are dropped
                    next_r.pslverr = 1'b1;
                end
            endcase
        end
        // hardware set wins over a same-cycle clear
        if (sent_pulse) begin
            next_r.status[IRQ_SENT] = 1'b1;
        end
        if (drop_pulse) begin
            next_r.status[IRQ_DROP] = 1'b1;
        end
        next_r.irq = |(next_r.status & next_r.irq_enable);
        if (srst) begin
            next_r = '0;
            next_r.msg_link = NEXT_LINK_RESET; // RQ2
            next_r.sub_link = NEXT_LINK_RESET; // RQ12
            next_r.cfg_unlocked = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        r <= next_r;
    end

    // RQ9 relies on software: target is used as programmed
    mscr_sender u_sender (
        .ref_clk     (ref_clk),
        .srst        (srst),
        .enable      (r.msg_enable), // RQ3
        .event_pulse (irq_event),
        .addr_low    ({r.addr_low, 2'b00}),
        .addr_high   (r.addr_high),
        .payload     (r.payload),
        .wr_ready    (wr_ready),
        .wr_valid    (wr_valid),
        .wr_wide     (wr_wide),
        .wr_addr     (wr_addr),
        .wr_data     (wr_data),
        .sent_pulse  (sent_pulse),
        .drop_pulse  (drop_pulse)
    );

    assign pready  = r.pready;
    assign pslverr = r.pslverr;
    assign prdata  = r.prdata;
    assign irq     = r.irq;
endmodule : mscr_regs
`default_nettype wire

// ### mscr_pkg.sv
// constants and types for the message interrupt and subsystem register bank
package mscr_pkg;
    localparam logic [11:0] OFF_MSG_CTRL      = 12'h0d0;
    localparam logic [11:0] OFF_MSG_ADDR_LO   = 12'h0d4;
    localparam logic [11:0] OFF_MSG_ADDR_HI   = 12'h0d8;
    localparam logic [11:0] OFF_MSG_PAYLOAD   = 12'h0dc;
    localparam logic [11:0] OFF_SUB_HDR       = 12'h0f0;
    localparam logic [11:0] OFF_SUB_ID        = 12'h0f4;
    localparam logic [11:0] OFF_IRQ_STATUS    = 12'h100;
    localparam logic [11:0] OFF_IRQ_ENABLE    = 12'h104;
    localparam logic [11:0] OFF_IRQ_CLEAR     = 12'h108;
    localparam logic [11:0] OFF_LOCK          = 12'h10c;

    localparam logic [7:0]  MSG_CAP_ID        = 8'h05;
    localparam logic [7:0]  SUB_CAP_ID        = 8'h0d;
    localparam logic [7:0]  NEXT_LINK_RESET   = 8'h00;
    localparam logic [2:0]  REQ_COUNT_VALUE   = 3'h0;
    localparam logic        WIDE_ADDR_VALUE   = 1'b1;
    localparam int          LINK_LSB          = 8;
    localparam int          ENABLE_BIT        = 16;
    localparam int          REQ_COUNT_LSB     = 17;
    localparam int          GRANT_COUNT_LSB   = 20;
    localparam int          WIDE_BIT          = 23;
    localparam int          MAKER_LSB         = 0;
    localparam int          BOARD_LSB         = 16;

    // status bits: 0 message sent, 1 event dropped while disabled
    localparam int          IRQ_BITS          = 2;
    localparam int          IRQ_SENT          = 0;
    localparam int          IRQ_DROP          = 1;

    typedef enum logic [1:0] {
        MSCR_IDLE,
        MSCR_SEND,
        MSCR_WAIT
    } mscr_state_t;
endpackage : mscr_pkg

// ### mscr_sender.sv
// issues one posted memory write per interrupt event taken in idle; events during a send or wait are ignored
`timescale 1ns/1ps
`default_nettype none
module mscr_sender (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        enable,
    input  wire logic        event_pulse,
    input  wire logic [31:0] addr_low,
    input  wire logic [31:0] addr_high,
    input  wire logic [15:0] payload,
    input  wire logic        wr_ready,
    output logic             wr_valid,
    output logic             wr_wide,
    output logic [63:0]      wr_addr,
    output logic [31:0]      wr_data,
    output logic             sent_pulse,
    output logic             drop_pulse
);
    import mscr_pkg::*;

    typedef struct packed {
        mscr_state_t state;
        logic        valid;
        logic        wide;
        logic [63:0] addr;
        logic [31:0] data;
        logic        sent;
        logic        drop;
    } mscr_snd_t;

    mscr_snd_t r;
    mscr_snd_t next_r;

    always_comb begin
        next_r      = r;
        next_r.sent = 1'b0;
        next_r.drop = 1'b0;
        unique case (r.state)
            MSCR_IDLE: begin
                if (event_pulse && enable) begin
                    next_r.state = MSCR_SEND;
                    next_r.valid = 1'b1;
                    next_r.wide  = (addr_high != 32'h0000_0000); // RQ8
                    next_r.addr  = (addr_high != 32'h0000_0000) ?
                                   {addr_high, addr_low[31:2], 2'b00} :
                                   {32'h0000_0000, addr_low[31:2], 2'b00};
                    // single message granted: payload never altered
                    next_r.data  = {16'h0000, payload}; // RQ5 RQ10
                end else if (event_pulse) begin
                    next_r.drop = 1'b1; // RQ3
                end
            end
            MSCR_SEND: begin
                if (wr_ready) begin
                    next_r.valid = 1'b0;
                    next_r.sent  = 1'b1; // RQ15
                    next_r.state = MSCR_WAIT;
                end
            end
            MSCR_WAIT: begin
                next_r.state = MSCR_IDLE;
            end
            default: begin
                next_r.state = MSCR_IDLE;
            end
        endcase
        if (srst) begin
            next_r       = '0;
            next_r.state = MSCR_IDLE;
        end
    end

    always_ff @(posedge ref_clk) begin
        r <= next_r;
    end

    assign wr_valid   = r.valid;
    assign wr_wide    = r.wide;
    assign wr_addr    = r.addr;
    assign wr_data    = r.data;
    assign sent_pulse = r.sent;
    assign drop_pulse = r.drop;
endmodule : mscr_sender
`default_nettype wire

// ### mscr_props.sv
// assertions on the register bank ports
`timescale 1ns/1ps
`default_nettype none
module mscr_props (
    input wire logic        ref_clk,
    input wire logic        srst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic        irq_event,
    input wire logic        wr_ready,
    input wire logic        wr_valid,
    input wire logic        wr_wide,
    input wire logic [63:0] wr_addr,
    input wire logic [31:0] wr_data,
    input wire logic        irq
);
    import mscr_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic rd_ok;
    assign rd_ok = pready && !pwrite && !pslverr;
    property p_apb_wait;
        psel && penable && !pready |=> pready;
    endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("pready late");
    property p_msg_hdr;
        rd_ok && paddr == OFF_MSG_CTRL |-> prdata[7:0] == MSG_CAP_ID
            && prdata[19:17] == 3'h0 && prdata[23] && prdata[31:24] == 8'h00;
    endproperty
    a_msg_hdr: assert property (p_msg_hdr) else $error("bad header");
    property p_lo;
        rd_ok && paddr == OFF_MSG_ADDR_LO |-> prdata[1:0] == 2'b00;
    endproperty
    a_lo: assert property (p_lo) else $error("low address unaligned");
    property p_pl;
        rd_ok && paddr == OFF_MSG_PAYLOAD |-> prdata[31:16] == 16'h0000;
    endproperty
    a_pl: assert property (p_pl) else $error("payload top set");
    property p_sub;
        rd_ok && paddr == OFF_SUB_HDR |-> prdata[7:0] == SUB_CAP_ID
            && prdata[31:16] == 16'h0000;
    endproperty
    a_sub: assert property (p_sub) else $error("bad sub header");
    property p_wide;
        wr_valid |-> wr_wide == (wr_addr[63:32] != 32'h0000_0000)
            && wr_addr[1:0] == 2'b00 && wr_data[31:16] == 16'h0000;
    endproperty
    a_wide: assert property (p_wide) else $error("bad write form");
    property p_hold;
        wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr)
            && $stable(wr_data);
    endproperty
    a_hold: assert property (p_hold) else $error("write dropped");
    property p_done;
        wr_valid && wr_ready |=> !wr_valid;
    endproperty
    a_done: assert property (p_done) else $error("write repeated");
    property p_cause;
        $rose(wr_valid) |-> $past(irq_event);
    endproperty
    a_cause: assert property (p_cause) else $error("write uncaused");
    c_send: cover property (wr_valid && wr_ready);
    c_err: cover property (pready && pslverr);
    c_irq: cover property ($rose(irq));
endmodule // mscr_props
`default_nettype wire

// ### mscr_sink.sv
// far-side acceptor of the interrupt memory writes
`timescale 1ns/1ps
`default_nettype none
module mscr_sink (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic [3:0]  dly,
    input  wire logic        wr_valid,
    input  wire logic        wr_wide,
    input  wire logic [63:0] wr_addr,
    input  wire logic [31:0] wr_data,
    output logic             wr_ready
);
    import mscr_pkg::*;
    logic [3:0]  cnt;
    logic [96:0] got [$];
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cnt      <= 4'h0;
            wr_ready <= 1'b0;
        end else if (wr_valid && wr_ready) begin
            got.push_back({wr_wide, wr_addr, wr_data});
            cnt      <= 4'h0;
            wr_ready <= 1'b0;
        end else if (wr_valid) begin
            cnt      <= cnt + 4'h1;
            wr_ready <= (cnt >= dly);
        end
    end
endmodule // mscr_sink
`default_nettype wire

// ### mscr_regs_test.sv
// self-checking bench for the register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin \
    mismatches++; $display("unexpected %s exp %h got %h", n, e, s); end end
module mscr_regs_test;
    import mscr_pkg::*;
    logic        ref_clk, srst, psel, penable, pwrite, pready, pslverr;
    logic        irq_event, wr_ready, wr_valid, wr_wide, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, wr_data, rd, v, lo, hi, pl, bm;
    logic [3:0]  pstrb, dly, sb;
    logic [63:0] wr_addr;
    int          mismatches, checks;
    logic [11:0] offs [6] = '{OFF_MSG_CTRL, OFF_MSG_ADDR_LO, OFF_MSG_ADDR_HI,
                              OFF_MSG_PAYLOAD, OFF_SUB_HDR, OFF_SUB_ID};
    logic [31:0] rstv [6] = '{32'h0080_0005, 0, 0, 0, 32'h0000_000d, 0};
    logic [31:0] wmsk [6] = '{32'h0071_ff00, 32'hffff_fffc, 32'hffff_ffff,
                              32'h0000_ffff, 32'h0000_ff00, 32'hffff_ffff};
    logic [31:0] lmsk [6] = '{32'h0000_ff00, 0, 0, 0, 32'h0000_ff00,
                              32'hffff_ffff};
    logic [31:0] mv [6];
    mscr_regs uut (.ref_clk(ref_clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .irq_event(irq_event), .wr_ready(wr_ready), .wr_valid(wr_valid),
        .wr_wide(wr_wide), .wr_addr(wr_addr), .wr_data(wr_data), .irq(irq));
    mscr_sink sink (.ref_clk(ref_clk), .srst(srst), .dly(dly),
        .wr_valid(wr_valid), .wr_wide(wr_wide), .wr_addr(wr_addr),
        .wr_data(wr_data), .wr_ready(wr_ready));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic wrap_up;
        if (mismatches == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k == 20) mismatches++;
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic check_all;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, offs[i], 32'h0);
            `CHK("register", mv[i], rd)
        end
    endtask
    task automatic fire(input int sends, input int len);
        int k;
        @(posedge ref_clk);
        irq_event <= 1'b1;
        repeat (len) @(posedge ref_clk);
        irq_event <= 1'b0;
        k = 0;
        while (sink.got.size() < sends && k < 40) begin
            @(posedge ref_clk);
            k++;
        end
        repeat (4) @(posedge ref_clk);
    endtask
    initial begin
        #(50 * 6000);
        mismatches++;
        wrap_up;
    end
    initial begin
        void'($urandom(32'hb0db41aa));
        {psel, penable, pwrite, irq_event} = 4'h0;
        {paddr, pwdata, pstrb, dly} = {12'h0, 32'h0, 4'hf, 4'h0};
        srst = 1'b1;
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        mv = rstv;
        check_all();
        for (int j = 0; j < 4; j++) begin
            for (int i = 0; i < 6; i++) begin
                v = (j == 0) ? 32'hffff_ffff : $urandom;
                // later rounds use random byte strobes
                sb = (j < 2) ? 4'hf : 4'($urandom);
                bm = {{8{sb[3]}}, {8{sb[2]}}, {8{sb[1]}}, {8{sb[0]}}};
                pstrb <= sb;
                apb(1'b1, offs[i], v);
                mv[i] = rstv[i] | (((mv[i] & ~bm) | (v & bm)) & wmsk[i]);
            end
            check_all();
        end
        pstrb <= 4'hf;
        apb(1'b1, OFF_LOCK, 32'h0);
        for (int i = 0; i < 6; i++) begin
            v = $urandom;
            apb(1'b1, offs[i], v);
            mv[i] = (mv[i] & lmsk[i]) | rstv[i] | (v & wmsk[i] & ~lmsk[i]);
        end
        check_all();
        apb(1'b1, OFF_LOCK, 32'h0000_0001);
        apb(1'b0, OFF_LOCK, 32'h0);
        `CHK("lock", 32'h0000_0001, rd)
        apb(1'b0, 12'h0e0, 32'h0);
        `CHK("unmapped", 33'h1_0000_0000, {err, rd})
        apb(1'b1, OFF_IRQ_STATUS, 32'hffff_ffff);
        `CHK("status write", 1'b1, err)
        apb(1'b1, OFF_IRQ_ENABLE, 32'h0000_0003);
        apb(1'b0, OFF_IRQ_ENABLE, 32'h0);
        `CHK("irq enable", 32'h0000_0003, rd)
        apb(1'b1, OFF_MSG_CTRL, 32'h0001_0000);
        for (int j = 0; j < 4; j++) begin
            lo = $urandom;
            hi = (j % 2) ? $urandom : 32'h0;
            pl = $urandom;
            apb(1'b1, OFF_MSG_ADDR_LO, lo);
            apb(1'b1, OFF_MSG_ADDR_HI, hi);
            apb(1'b1, OFF_MSG_PAYLOAD, pl);
            dly <= 4'($urandom % 6);
            fire(j + 1, (j == 0) ? 2 : 1);
            `CHK("sends", j + 1, sink.got.size())
            `CHK("write", {hi != 0, hi, lo & 32'hffff_fffc, 16'h0, pl[15:0]},
                 sink.got[j])
            `CHK("irq set", 1'b1, irq)
            apb(1'b1, OFF_IRQ_CLEAR, 32'h0000_0001);
            repeat (2) @(posedge ref_clk);
            `CHK("irq clear", 1'b0, irq)
        end
        apb(1'b1, OFF_MSG_CTRL, 32'h0);
        fire(5, 1);
        `CHK("sends off", 4, sink.got.size())
        apb(1'b0, OFF_IRQ_STATUS, 32'h0);
        `CHK("status", 32'h0000_0002, rd)
        `CHK("irq drop", 1'b1, irq)
        apb(1'b1, OFF_IRQ_ENABLE, 32'h0);
        repeat (2) @(posedge ref_clk);
        `CHK("irq masked", 1'b0, irq)
        wrap_up;
    end
endmodule // mscr_regs_test
bind mscr_regs mscr_props chk (.ref_clk(ref_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .irq_event(irq_event), .wr_ready(wr_ready), .wr_valid(wr_valid),
    .wr_wide(wr_wide), .wr_addr(wr_addr), .wr_data(wr_data), .irq(irq));
`default_nettype wire
